//--- core/mprs_readout.sv
// pattern register staggered readout path with an ahb-lite register slave
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module mprs_readout (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  // ahb-lite slave
  input  wire logic                          i_hsel,
  input  wire logic [31:0]                   i_haddr,
  input  wire logic [1:0]                    i_htrans,
  input  wire logic                          i_hwrite,
  input  wire logic [2:0]                    i_hsize,
  input  wire logic [31:0]                   i_hwdata,
  input  wire logic                          i_hready,
  output logic      [31:0]                   o_hrdata,
  output logic                               o_hreadyout,
  output logic                               o_hresp,
  // command pins from the memory controller
  input  wire logic                          i_cmd_rd,
  input  wire logic [1:0]                    i_ba,
  input  wire logic                          i_bg,
  input  wire logic [mprs_pkg::ADDR_BITS-1:0] i_addr,
  // data pins
  output logic      [mprs_pkg::LANES-1:0]    o_dq,
  output logic      [mprs_pkg::LANES-1:0]    o_dq_oe,
  output logic                               o_dqs,
  output logic                               o_dqs_oe,
  output logic                               o_core_rd
);

  // ---------------- register slave ----------------
  mprs_pkg::mprs_cfg_t cfg;
  logic [31:0]         ctrl_reg;
  logic [31:0]         lat_reg;
  logic [31:0]         pattern_reg;
  logic                addr_err_reg;
  logic [mprs_pkg::CNT_BITS-1:0] rd_cnt_reg;
  logic                busy;

  logic                wr_pend_reg;
  logic [7:0]          wr_ofs_reg;
  logic [31:0]         hrdata_next;
  logic                aphase;

  assign aphase = i_hsel && i_hready && i_htrans[1];

  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (i_haddr[7:0])
      mprs_pkg::OFS_CTRL:    hrdata_next = ctrl_reg;
      mprs_pkg::OFS_LAT:     hrdata_next = lat_reg;
      mprs_pkg::OFS_STATUS: begin
        hrdata_next[mprs_pkg::ST_BUSY]     = busy;
        hrdata_next[mprs_pkg::ST_ADDR_ERR] = addr_err_reg;
        hrdata_next[mprs_pkg::ST_CNT_LO +: mprs_pkg::CNT_BITS] = rd_cnt_reg;
      end
      mprs_pkg::OFS_PATTERN: hrdata_next = pattern_reg;
      default:               hrdata_next = 32'h0000_0000;
    endcase
  end

  // zero wait states: read data is registered off the address phase
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_reg <= aphase && i_hwrite;
      if (aphase) begin
        wr_ofs_reg <= i_haddr[7:0];
        o_hrdata   <= i_hwrite ? 32'h0000_0000 : hrdata_next;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_reg    <= 32'h0000_0000;
      lat_reg     <= mprs_pkg::LAT_RST;
      pattern_reg <= mprs_pkg::PATTERN_RST;
    end else if (wr_pend_reg) begin
      case (wr_ofs_reg)
        mprs_pkg::OFS_CTRL:    ctrl_reg    <= {25'h0, i_hwdata[6:0]};
        mprs_pkg::OFS_LAT:     lat_reg     <= {16'h0, i_hwdata[15:0]};
        mprs_pkg::OFS_PATTERN: pattern_reg <= i_hwdata;
        default:               ctrl_reg    <= ctrl_reg;
      endcase
    end
  end

  always_comb begin
    cfg.mode_en        = ctrl_reg[mprs_pkg::CTRL_MODE];
    cfg.width          = mprs_pkg::mprs_width_t'(ctrl_reg[mprs_pkg::CTRL_WID_LO +: 2]);
    cfg.bl_field       = ctrl_reg[mprs_pkg::CTRL_BL_LO +: 2];
    cfg.parity_en      = ctrl_reg[mprs_pkg::CTRL_PAR];
    cfg.pre2           = ctrl_reg[mprs_pkg::CTRL_PRE2];
    cfg.cl             = lat_reg[mprs_pkg::LAT_CL_LO +: mprs_pkg::LAT_BITS];
    cfg.al             = lat_reg[mprs_pkg::LAT_AL_LO +: mprs_pkg::LAT_BITS];
    cfg.parity_latency = lat_reg[mprs_pkg::LAT_PL_LO +: mprs_pkg::PL_BITS];
  end

  // ---------------- command pins: two-flop synchronisers ----------------
  localparam int unsigned PIN_W = 1 + 2 + 1 + mprs_pkg::ADDR_BITS;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {i_cmd_rd, i_ba, i_bg, i_addr};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic                          s_rd;
  logic [1:0]                    s_ba;
  logic [mprs_pkg::ADDR_BITS-1:0] s_addr;

  // bank group and a10 sit in the bundle but are never decoded
  assign s_rd   = pin_sync_reg[PIN_W-1];
  assign s_ba   = pin_sync_reg[PIN_W-2 -: 2];
  assign s_addr = pin_sync_reg[mprs_pkg::ADDR_BITS-1:0];

  // ---------------- command acceptance ----------------
  mprs_pkg::mprs_cmd_t new_cmd;
  logic                addr_bad;

  always_comb begin
    new_cmd.vld = s_rd && cfg.mode_en;
    new_cmd.loc = s_ba;
    // location order is fixed, so a1:0, a2 and a12 only get checked
    addr_bad = (s_addr[1:0] != 2'h0) ||
               (s_addr[mprs_pkg::A_BIT2] && cfg.bl_field == mprs_pkg::BL_FIXED8);
    if (cfg.bl_field == mprs_pkg::BL_OTF && !s_addr[mprs_pkg::A_BIT12]) begin
      addr_bad = 1'b1;
    end
  end

  // with the mode bit low, reads go back to the normal core path
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_core_rd <= 1'b0;
    end else begin
      o_core_rd <= s_rd && !cfg.mode_en;
    end
  end

  logic status_wr_clr;
  assign status_wr_clr = wr_pend_reg && wr_ofs_reg == mprs_pkg::OFS_STATUS &&
                         i_hwdata[mprs_pkg::ST_ADDR_ERR];

  // sticky error: a new event in the clearing cycle wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      addr_err_reg <= 1'b0;
    end else if (new_cmd.vld && addr_bad) begin
      addr_err_reg <= 1'b1;
    end else if (status_wr_clr) begin
      addr_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_cnt_reg <= '0;
    end else if (new_cmd.vld) begin
      rd_cnt_reg <= rd_cnt_reg + 1'b1;
    end
  end

  // ---------------- read latency line ----------------
  // total latency saturates at the line depth minus one
  logic [mprs_pkg::LAT_BITS+1:0] lat_sum;
  logic [mprs_pkg::LAT_BITS-1:0] lat_data;
  logic [mprs_pkg::LAT_BITS-1:0] lat_pre;
  logic [1:0]                    pre_len;

  always_comb begin
    lat_sum = {2'b00, cfg.cl} + {2'b00, cfg.al};
    if (cfg.parity_en) begin
      lat_sum = lat_sum + {4'h0, cfg.parity_latency};
    end
    lat_data = (lat_sum > (mprs_pkg::LINE_DEPTH - 1)) ?
               mprs_pkg::LAT_BITS'(mprs_pkg::LINE_DEPTH - 1) : lat_sum[mprs_pkg::LAT_BITS-1:0];
    pre_len  = cfg.pre2 ? mprs_pkg::PRE_2TCK : mprs_pkg::PRE_1TCK;
    lat_pre  = (lat_data > {4'h0, pre_len}) ? lat_data - {4'h0, pre_len} : '0;
  end

  mprs_pkg::mprs_cmd_t line_reg [mprs_pkg::LINE_DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      line_reg[0] <= '0;
    end else begin
      line_reg[0] <= new_cmd;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < mprs_pkg::LINE_DEPTH; gi++) begin : g_line
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          line_reg[gi] <= '0;
        end else begin
          line_reg[gi] <= line_reg[gi-1];
        end
      end
    end
  endgenerate

  mprs_pkg::mprs_cmd_t tap_data;
  mprs_pkg::mprs_cmd_t tap_pre;
  assign tap_data = line_reg[lat_data];
  assign tap_pre  = line_reg[lat_pre];

  // ---------------- burst engine ----------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_BURST
  } mprs_state_t;

  mprs_state_t state_reg;
  logic [2:0]  ui_reg;
  logic [1:0]  loc_reg;
  logic [1:0]  pre_cnt_reg;

  assign busy = state_reg != ST_IDLE;

  // a new tap at the last ui chains straight on, no bubble
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg   <= ST_IDLE;
      ui_reg      <= 3'h0;
      loc_reg     <= 2'h0;
      pre_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (tap_data.vld) begin
            state_reg <= ST_BURST;
            ui_reg    <= 3'h0;
            loc_reg   <= tap_data.loc;
          end else if (tap_pre.vld) begin
            state_reg   <= ST_PRE;
            pre_cnt_reg <= pre_len;
          end
        end
        ST_PRE: begin
          if (tap_data.vld) begin
            state_reg <= ST_BURST;
            ui_reg    <= 3'h0;
            loc_reg   <= tap_data.loc;
          end else if (pre_cnt_reg == 2'h1) begin
            state_reg <= ST_IDLE;
          end else begin
            pre_cnt_reg <= pre_cnt_reg - 2'h1;
          end
        end
        ST_BURST: begin
          if (tap_data.vld) begin
            ui_reg  <= 3'h0;
            loc_reg <= tap_data.loc;
          end else if (ui_reg == 3'(mprs_pkg::UI_PER_BURST - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            ui_reg <= ui_reg + 3'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // next-cycle lane values, so the pins come straight from flops
  logic        drive_next;
  logic [2:0]  ui_next;
  logic [1:0]  loc_next;

  always_comb begin
    drive_next = 1'b0;
    ui_next    = ui_reg;
    loc_next   = loc_reg;
    if (tap_data.vld && state_reg != ST_IDLE || tap_data.vld) begin
      drive_next = 1'b1;
      ui_next    = 3'h0;
      loc_next   = tap_data.loc;
    end else if (state_reg == ST_BURST && ui_reg != 3'(mprs_pkg::UI_PER_BURST - 1)) begin
      drive_next = 1'b1;
      ui_next    = ui_reg + 3'h1;
    end
  end

  logic lane_en [mprs_pkg::LANES];

  generate
    for (gi = 0; gi < mprs_pkg::LANES; gi++) begin : g_lane
      localparam logic [1:0] OFS = 2'(gi % mprs_pkg::NIBBLE);
      logic [1:0] lane_loc;
      // every nibble uses the same rotation, so upper lanes copy lower
      assign lane_loc = loc_next + OFS;
      assign lane_en[gi] = (gi < mprs_pkg::NIBBLE) ||
                           (gi < 2 * mprs_pkg::NIBBLE && cfg.width != mprs_pkg::MPRS_X4) ||
                           (cfg.width == mprs_pkg::MPRS_X16);
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          o_dq[gi]    <= 1'b1;
          o_dq_oe[gi] <= 1'b0;
        end else begin
          o_dq_oe[gi] <= drive_next && lane_en[gi];
          o_dq[gi]    <= drive_next ?
                         pattern_reg[lane_loc * mprs_pkg::LOC_BITS + ui_next] : 1'b1;
        end
      end
    end
  endgenerate

  // strobe: low during preamble, toggles one edge per ui in the burst
  logic pre_next;
  assign pre_next = !drive_next &&
                    ((state_reg == ST_IDLE && tap_pre.vld) ||
                     (state_reg == ST_PRE && pre_cnt_reg != 2'h1));

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
    end else begin
      o_dqs_oe <= drive_next || pre_next;
      o_dqs    <= drive_next ? !ui_next[0] : 1'b0;
    end
  end

endmodule : mprs_readout

//--- core/mprs_pkg.sv
// shared constants and types for the staggered pattern readout block
package mprs_pkg;

  localparam int unsigned NUM_LOC       = 4;
  localparam int unsigned LOC_BITS      = 8;
  localparam int unsigned LANES         = 16;
  localparam int unsigned NIBBLE        = 4;
  localparam int unsigned UI_PER_BURST  = 8;
  localparam int unsigned ADDR_BITS     = 14;
  localparam int unsigned LINE_DEPTH    = 64;
  localparam int unsigned LAT_BITS      = 6;

  // address pin positions
  localparam int unsigned A_BIT2        = 2;
  localparam int unsigned A_BIT12       = 12;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_LAT        = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_PATTERN    = 8'h0C;

  // ctrl fields
  localparam int unsigned CTRL_MODE     = 0;
  localparam int unsigned CTRL_WID_LO   = 1;
  localparam int unsigned CTRL_BL_LO    = 3;
  localparam int unsigned CTRL_PAR      = 5;
  localparam int unsigned CTRL_PRE2     = 6;

  // latency fields
  localparam int unsigned LAT_CL_LO     = 0;
  localparam int unsigned LAT_AL_LO     = 6;
  localparam int unsigned LAT_PL_LO     = 12;
  localparam int unsigned PL_BITS       = 4;

  // status fields
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_ADDR_ERR   = 1;
  localparam int unsigned ST_CNT_LO     = 8;
  localparam int unsigned CNT_BITS      = 8;

  // burst length field encodings
  localparam logic [1:0] BL_FIXED8      = 2'h0;
  localparam logic [1:0] BL_OTF         = 2'h1;
  localparam logic [1:0] BL_CHOP4       = 2'h2;

  localparam logic [1:0] PRE_1TCK       = 2'h1;
  localparam logic [1:0] PRE_2TCK       = 2'h2;

  localparam logic [31:0] PATTERN_RST   = 32'h0000_0000;
  localparam logic [31:0] LAT_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    MPRS_X4,
    MPRS_X8,
    MPRS_X16
  } mprs_width_t;

  typedef struct packed {
    logic       vld;
    logic [1:0] loc;
  } mprs_cmd_t;

  typedef struct packed {
    logic                mode_en;
    mprs_width_t         width;
    logic [1:0]          bl_field;
    logic                parity_en;
    logic                pre2;
    logic [LAT_BITS-1:0] cl;
    logic [LAT_BITS-1:0] al;
    logic [PL_BITS-1:0]  parity_latency;
  } mprs_cfg_t;

endpackage : mprs_pkg

//--- testbench/mprs_readout_chk.sv
// pin-level assertion checker for the pattern readout block
`timescale 1ns/10ps
module mprs_readout_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_cmd_rd,
  input wire logic        o_hresp,
  input wire logic        o_hreadyout,
  input wire logic [15:0] o_dq,
  input wire logic [15:0] o_dq_oe,
  input wire logic        o_dqs,
  input wire logic        o_dqs_oe,
  input wire logic        o_core_rd
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_resp_okay: assert property (!o_hresp)
    else $error("bus slave gave an error response");
  a_ready_zero: assert property (!$past(i_rst) |-> o_hreadyout)
    else $error("bus slave inserted a wait state");
  a_idle_high: assert property (o_dq_oe == 16'h0000 |-> o_dq == 16'hFFFF)
    else $error("undriven lanes not parked high");
  a_burst_eight: assert property ($rose(o_dq_oe[0]) |-> o_dq_oe[0] [*8])
    else $error("data burst shorter than eight beats");
  a_strobe_first: assert property ($rose(o_dq_oe[0]) |-> o_dqs && $past(o_dqs_oe) && !$past(o_dqs))
    else $error("strobe preamble or first edge wrong");
  a_strobe_toggle: assert property (o_dq_oe[0] && $past(o_dq_oe[0]) |-> o_dqs != $past(o_dqs))
    else $error("strobe did not toggle within burst");
  a_strobe_on: assert property (o_dq_oe[0] |-> o_dqs_oe)
    else $error("data driven without strobe");
  a_nibble_copy: assert property (o_dq_oe[4] |-> o_dq[7:4] == o_dq[3:0])
    else $error("upper nibble differs from lower nibble");
  a_byte_copy: assert property (o_dq_oe[8] |-> o_dq[15:8] == o_dq[7:0])
    else $error("upper byte differs from lower byte");
  // pin sampled high one edge after launch, then two sync flops and the output flop
  a_core_delay: assert property (o_core_rd |-> $past(i_cmd_rd, 3))
    else $error("core read pulse without matching command");
endmodule : mprs_readout_chk

bind mprs_readout mprs_readout_chk u_mprs_readout_chk (.i_core_clk, .i_rst, .i_cmd_rd, .o_hresp, .o_hreadyout,
  .o_dq, .o_dq_oe, .o_dqs, .o_dqs_oe, .o_core_rd);

//--- testbench/mprs_ctrl_model.sv
// memory controller model that issues pattern read commands
`timescale 1ns/10ps
module mprs_ctrl_model #(
  parameter int GAP = 8
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic [1:0] i_loc,
  input  wire logic [3:0] i_num,
  input  wire logic       i_a12,
  input  wire logic       i_bad,
  output logic            o_cmd_rd,
  output logic [1:0]      o_ba,
  output logic            o_bg,
  output logic [13:0]     o_addr
);
  logic [3:0] left_reg = 4'h0;
  logic [3:0] wait_reg = 4'h0;
  logic [1:0] loc_reg  = 2'h0;
  initial begin
    o_cmd_rd = 1'b0;
    o_ba     = 2'h0;
    o_bg     = 1'b0;
    o_addr   = 14'h0;
  end
  always @(posedge i_core_clk) begin
    // unsampled pins flip so a stale value can never pass
    o_cmd_rd <= 1'b0;
    o_ba     <= ~o_ba;
    o_bg     <= ~o_bg;
    o_addr   <= ~o_addr;
    if (i_go) begin
      left_reg <= i_num;
      wait_reg <= 4'h0;
      loc_reg  <= i_loc;
    end else if (left_reg != 4'h0 && wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else if (left_reg != 4'h0) begin
      o_cmd_rd <= 1'b1;
      o_ba     <= loc_reg;
      o_addr   <= {~o_addr[13], i_a12, ~o_addr[11:3], 1'b0, 1'b0, i_bad};
      loc_reg  <= loc_reg + 2'h1;
      left_reg <= left_reg - 4'h1;
      wait_reg <= 4'(GAP - 1);
    end
  end
endmodule : mprs_ctrl_model

//--- testbench/tb_mprs_readout.sv
// self-checking bench for the staggered pattern readout
`timescale 1ns/10ps
module tb_mprs_readout;
  localparam logic [31:0] PAT = 32'hA5C30F81;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        go     = 1'b0;
  logic        a12    = 1'b0;
  logic        bad    = 1'b0;
  logic [1:0]  go_loc = 2'h0;
  logic [3:0]  go_num = 4'h1;
  logic [31:0] hrdata, t;
  logic        rdy, resp, cmd, bg, core_rd, dqs, dqs_oe;
  logic [1:0]  ba;
  logic [13:0] addr;
  logic [15:0] dq, dq_oe;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  mprs_readout u_mprs_readout (
    .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp),
    .i_cmd_rd(cmd), .i_ba(ba), .i_bg(bg), .i_addr(addr), .o_dq(dq), .o_dq_oe(dq_oe), .o_dqs(dqs),
    .o_dqs_oe(dqs_oe), .o_core_rd(core_rd));

  mprs_ctrl_model u_mprs_ctrl_model (
    .i_core_clk(clk), .i_go(go), .i_loc(go_loc), .i_num(go_num), .i_a12(a12), .i_bad(bad),
    .o_cmd_rd(cmd), .o_ba(ba), .o_bg(bg), .o_addr(addr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    t = hrdata;
  endtask : ahb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(t & m, e);
  endtask : rd

  task automatic burst(input logic [1:0] loc, input int num, input int lat, input logic [15:0] m);
    int          n;
    logic [15:0] e;
    @(posedge clk);
    go_loc <= loc;
    go_num <= 4'(num);
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    n = 0;
    @(negedge clk);
    while (dq_oe[0] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), 32'(lat + 3));
    for (int b = 0; b < num; b++)
      for (int u = 0; u < 8; u++) begin
        for (int k = 0; k < 16; k++) e[k] = PAT[8 * ((loc + b + k) % 4) + u];
        chk({16'h0, dq & m}, {16'h0, e & m});
        chk({16'h0, dq_oe}, {16'h0, m});
        @(negedge clk);
      end
    // next bus request must start right after a rising edge
    @(posedge clk);
  endtask : burst

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(mprs_pkg::OFS_PATTERN, 32'hFFFFFFFF, mprs_pkg::PATTERN_RST);
    rd(mprs_pkg::OFS_LAT, 32'hFFFFFFFF, mprs_pkg::LAT_RST);
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, mprs_pkg::OFS_PATTERN, PAT);
    ahb(1'b1, mprs_pkg::OFS_LAT, 32'h00000085);
    for (int w = 0; w < 3; w++) begin
      ahb(1'b1, mprs_pkg::OFS_CTRL, 32'(2 * w + 1));
      burst(2'h1, 4, 7, w == 0 ? 16'h000F : w == 1 ? 16'h00FF : 16'hFFFF);
    end
    // twelve accepted reads so far, engine idle, no address error
    rd(mprs_pkg::OFS_STATUS, 32'hFF03, 32'h0C00);
    ahb(1'b1, mprs_pkg::OFS_LAT, 32'h00003085);
    ahb(1'b1, mprs_pkg::OFS_CTRL, 32'h00000065);
    burst(2'h3, 1, 10, 16'hFFFF);
    ahb(1'b1, mprs_pkg::OFS_CTRL, 32'h0000000D);
    a12 <= 1'b1;
    burst(2'h2, 1, 7, 16'hFFFF);
    rd(mprs_pkg::OFS_STATUS, 32'h2, 32'h0);
    a12 <= 1'b0;
    burst(2'h0, 1, 7, 16'hFFFF);
    rd(mprs_pkg::OFS_STATUS, 32'h2, 32'h2);
    ahb(1'b1, mprs_pkg::OFS_STATUS, 32'h2);
    rd(mprs_pkg::OFS_STATUS, 32'h2, 32'h0);
    ahb(1'b1, mprs_pkg::OFS_CTRL, 32'h5);
    bad <= 1'b1;
    burst(2'h1, 1, 7, 16'hFFFF);
    rd(mprs_pkg::OFS_STATUS, 32'h2, 32'h2);
    ahb(1'b1, mprs_pkg::OFS_CTRL, 32'h0);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // command launched next edge, pulse stands one cycle three edges later
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({31'h0, core_rd}, 32'h1);
    repeat (12) begin
      @(negedge clk);
      chk({16'h0, dq_oe}, 32'h0);
    end
    conclude();
  end

  // run should end well under this ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
endmodule : tb_mprs_readout
